// file: verilog/temp_mon_map.svh
`ifndef TEMP_MON_MAP_SVH
`define TEMP_MON_MAP_SVH

// timing
`define CLK_HZ          40_000_000
`define CONV_TIME_MS    170
`define RATE_BASE_S     16

// power-up values, fault reading and top rate code
`define RATE_RST        8'h02
`define HI_LIM_RST      8'h7F
`define LO_LIM_RST      8'hC9
`define PTR_RST         8'h00
`define CFG_RST         8'h00
`define FAULT_TEMP      8'h7F
`define RATE_MAX        8'h07

// command codes
`define CMD_RD_LTEMP    8'h00
`define CMD_RD_RTEMP    8'h01
`define CMD_RD_STATUS   8'h02
`define CMD_RD_CFG      8'h03
`define CMD_RD_RATE     8'h04
`define CMD_RD_LHL      8'h05
`define CMD_RD_LLL      8'h06
`define CMD_RD_RHL      8'h07
`define CMD_RD_RLL      8'h08
`define CMD_WR_CFG      8'h09
`define CMD_WR_RATE     8'h0A
`define CMD_WR_LHL      8'h0B
`define CMD_WR_LLL      8'h0C
`define CMD_WR_RHL      8'h0D
`define CMD_WR_RLL      8'h0E
`define CMD_ONESHOT     8'h0F

// status and config bits
`define ST_BUSY         7
`define ST_LHI          6
`define ST_LLO          5
`define ST_RHI          4
`define ST_RLO          3
`define ST_OPEN         2
`define CFG_STBY        6

`endif

// file: verilog/temp_mon_pkg.sv
package temp_mon_pkg;
  typedef logic [7:0] byte_t;
  typedef enum {L_IDLE, L_ADDR, L_CMD, L_WDATA, L_RDATA, L_RACK} link_state_t;
  typedef enum logic [1:0] {EV_CMD, EV_DATA, EV_READ} ev_kind_t;
endpackage

// file: verilog/sync2.sv
`timescale 1ns/100ps
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= '0;
      q_o    <= '0;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule

// file: verilog/conv_timer.sv
`timescale 1ns/100ps
`include "temp_mon_map.svh"
module conv_timer #(
  parameter int unsigned BASE_CYCLES = `RATE_BASE_S * `CLK_HZ
) (
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] rate_i,
  output logic            tick_o
);
  localparam int W = $clog2(BASE_CYCLES + 1);

  logic [W-1:0] cnt_q;
  // reserved codes run at the fastest rate
  wire  [2:0]   shift_w = (rate_i > `RATE_MAX) ? 3'h7 : rate_i[2:0];
  wire  [W-1:0] lim_w   = W'((BASE_CYCLES >> shift_w) - 1);

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q  <= '0;
      tick_o <= 1'b0;
    end else if (cnt_q >= lim_w) begin
      cnt_q  <= '0;
      tick_o <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 1'b1;
      tick_o <= 1'b0;
    end
  end

  a_tick_spacing: assert property (@(posedge mclk_i) disable iff (rst_i)
    tick_o |=> !tick_o) else $error("timer tick lasted more than one cycle");
endmodule

// file: verilog/smbus_temp_monitor_slave_port.sv
// How it works
// - reset releases the alert output
// - conversion rate code 02H after reset
// - limits reset to +127 high, -55 low
// - command pointer resets to zero
// - diode checked at each conversion start
// - faulty diode: alert, reading 127, flags
// - write byte stores data in register
// - read byte: command, restart, return byte
// - send byte carries only a command
// - receive byte returns selected register
// - only four transaction types supported
// - eight data bits plus acknowledge bit
// - answer only own seven-bit address
// - command byte updates command pointer
// - receive byte reuses previously selected register
// - one-shot obeys busy and hardware standby, runs in software standby
// - status bit 2 open, bit 4 high
// - flags clear on status read unless persisting
// - limits are two's complement bytes
`timescale 1ns/100ps
`include "temp_mon_map.svh"
module smbus_temp_monitor_slave_port
  import temp_mon_pkg::*;
#(
  parameter int unsigned CONV_CYCLES = `CONV_TIME_MS * (`CLK_HZ / 1000),
  parameter int unsigned RATE_CYCLES = `RATE_BASE_S * `CLK_HZ
) (
  // clocks and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  input  wire logic       link_clk_i,
  // serial link
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  input  wire logic [6:0] dev_addr_i,
  // alert, open drain
  output logic            alert_o,
  output logic            alert_oe_o,
  // sensor front end
  input  wire logic [7:0] local_temp_i,
  input  wire logic [7:0] remote_temp_i,
  input  wire logic       diode_open_i,
  input  wire logic       diode_short_i,
  input  wire logic       hw_standby_i,
  // status
  output logic            busy_o
);
  localparam int CW = $clog2(CONV_CYCLES + 1);

  // ---------------- link domain ----------------
  logic        scl_s, sda_s, scl_p_q, sda_p_q, rd_tgl_s, rd_seen_q;
  logic [6:0]  addr_s;
  link_state_t lst_q;
  logic [3:0]  cnt_q;
  byte_t       sh_q, tx_q, rd_link_q, ev_byte_q;
  logic        ack_q, rw_q, ev_tgl_q;
  ev_kind_t    ev_kind_q;

  // ---------------- core domain ----------------
  logic        ev_tgl_s, ev_seen_q, hw_stby_s, open_s, short_s, tick;
  byte_t       ltemp_s, rtemp_s;
  byte_t       ptr_q, rate_q, cfg_q, lhl_q, lll_q, rhl_q, rll_q;
  byte_t       ltemp_q, rtemp_q, flags_q, rd_byte_q;
  logic [CW-1:0] conv_cnt_q;
  logic        fault_q, fault_open_q, post_q, rd_tgl_q;

  sync2 #(.W(9)) u_lsync (
    .clk_i (link_clk_i),
    .rst_i (rst_i),
    .d_i   ({scl_i, sda_i, dev_addr_i}),
    .q_o   ({scl_s, sda_s, addr_s})
  );

  sync2 #(.W(1)) u_rsync (
    .clk_i (link_clk_i),
    .rst_i (rst_i),
    .d_i   (rd_tgl_q),
    .q_o   (rd_tgl_s)
  );

  // framing seen on the oversampled pins
  wire start_w = scl_s & scl_p_q & sda_p_q & ~sda_s;
  wire stop_w  = scl_s & scl_p_q & ~sda_p_q & sda_s;
  wire rise_w  = scl_s & ~scl_p_q;
  wire fall_w  = ~scl_s & scl_p_q;
  wire byte_w  = (cnt_q == 4'h8);
  wire match_w = (sh_q[7:1] == addr_s);
  link_state_t after_ack_w;
  assign after_ack_w = (lst_q == L_ADDR) ? L_CMD :
                       (lst_q == L_CMD)  ? L_WDATA : L_IDLE;

  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_p_q   <= 1'b1;
      sda_p_q   <= 1'b1;
      lst_q     <= L_IDLE;
      cnt_q     <= 4'h0;
      sh_q      <= 8'h00;
      tx_q      <= 8'h00;
      ack_q     <= 1'b0;
      rw_q      <= 1'b0;
      sda_o     <= 1'b0;
      sda_oe_o  <= 1'b0;
      ev_tgl_q  <= 1'b0;
      ev_kind_q <= EV_CMD;
      ev_byte_q <= 8'h00;
      rd_seen_q <= 1'b0;
      rd_link_q <= 8'h00;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      sda_o   <= 1'b0;
      // core loads rd_byte_q in the cycle it toggles; the sync delay lets it settle
      if (rd_tgl_s != rd_seen_q) begin
        rd_seen_q <= rd_tgl_s;
        rd_link_q <= rd_byte_q;
      end
      if (start_w) begin
        lst_q    <= L_ADDR;
        cnt_q    <= 4'h0;
        ack_q    <= 1'b0;
        sda_oe_o <= 1'b0;
      end else if (stop_w) begin
        lst_q    <= L_IDLE;
        ack_q    <= 1'b0;
        sda_oe_o <= 1'b0;
      end else if (rise_w && lst_q != L_IDLE && !ack_q) begin
        sh_q  <= {sh_q[6:0], sda_s};
        cnt_q <= cnt_q + 4'h1;
        if (lst_q == L_RACK) begin
          lst_q <= L_IDLE;
        end
      end else if (fall_w && lst_q != L_IDLE) begin
        if (ack_q) begin
          ack_q <= 1'b0;
          cnt_q <= 4'h0;
          if (lst_q == L_ADDR && rw_q) begin
            lst_q    <= L_RDATA;
            sda_oe_o <= ~rd_link_q[7];
            tx_q     <= {rd_link_q[6:0], 1'b0};
          end else begin
            lst_q    <= after_ack_w;
            sda_oe_o <= 1'b0;
          end
        end else if (byte_w) begin
          case (lst_q)
            L_ADDR: begin
              if (match_w) begin
                ack_q    <= 1'b1;
                sda_oe_o <= 1'b1;
                rw_q     <= sh_q[0];
                if (sh_q[0]) begin
                  ev_tgl_q  <= ~ev_tgl_q;
                  ev_kind_q <= EV_READ;
                end
              end else begin
                lst_q <= L_IDLE;
              end
            end
            L_CMD: begin
              ack_q     <= 1'b1;
              sda_oe_o  <= 1'b1;
              ev_tgl_q  <= ~ev_tgl_q;
              ev_kind_q <= EV_CMD;
              ev_byte_q <= sh_q;
            end
            L_WDATA: begin
              ack_q     <= 1'b1;
              sda_oe_o  <= 1'b1;
              ev_tgl_q  <= ~ev_tgl_q;
              ev_kind_q <= EV_DATA;
              ev_byte_q <= sh_q;
            end
            L_RDATA: begin
              sda_oe_o <= 1'b0;
              lst_q    <= L_RACK;
            end
            default: lst_q <= L_IDLE;
          endcase
        end else if (lst_q == L_RDATA) begin
          sda_oe_o <= ~tx_q[7];
          tx_q     <= {tx_q[6:0], 1'b0};
        end
      end
    end
  end

  a_idle_released: assert property (@(posedge link_clk_i) disable iff (rst_i)
    lst_q == L_IDLE && !start_w |=> !sda_oe_o) else $error("line driven while idle");
  a_ack_ninth: assert property (@(posedge link_clk_i) disable iff (rst_i)
    $rose(ack_q) |-> cnt_q == 4'h8 && sda_oe_o) else $error("ack not on ninth clock");
  a_addr_match: assert property (@(posedge link_clk_i) disable iff (rst_i)
    $rose(ack_q) && lst_q == L_ADDR |-> sh_q[7:1] == addr_s) else $error("acked foreign address");

  // ---------------- core domain logic ----------------
  // event fields are stable for many link clocks after the toggle
  sync2 #(.W(20)) u_msync (
    .clk_i (mclk_i),
    .rst_i (rst_i),
    .d_i   ({ev_tgl_q, hw_standby_i, diode_open_i, diode_short_i, local_temp_i,
             remote_temp_i}),
    .q_o   ({ev_tgl_s, hw_stby_s, open_s, short_s, ltemp_s, rtemp_s})
  );

  conv_timer #(.BASE_CYCLES(RATE_CYCLES)) u_timer (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .rate_i (rate_q),
    .tick_o (tick)
  );

  function automatic byte_t rd_mux(input byte_t p);
    case (p)
      `CMD_RD_LTEMP:  rd_mux = ltemp_q;
      `CMD_RD_RTEMP:  rd_mux = rtemp_q;
      `CMD_RD_STATUS: rd_mux = {busy_o, flags_q[6:0]};
      `CMD_RD_CFG:    rd_mux = cfg_q;
      `CMD_RD_RATE:   rd_mux = rate_q;
      `CMD_RD_LHL:    rd_mux = lhl_q;
      `CMD_RD_LLL:    rd_mux = lll_q;
      `CMD_RD_RHL:    rd_mux = rhl_q;
      `CMD_RD_RLL:    rd_mux = rll_q;
      default:        rd_mux = 8'h00;
    endcase
  endfunction

  wire   ev_now   = ev_tgl_s ^ ev_seen_q;
  wire   ev_cmd   = ev_now & (ev_kind_q == EV_CMD);
  wire   ev_data  = ev_now & (ev_kind_q == EV_DATA);
  wire   ev_read  = ev_now & (ev_kind_q == EV_READ);
  wire   oneshot  = ev_cmd & (ev_byte_q == `CMD_ONESHOT);
  // busy drops one-shots; hardware standby blocks everything
  wire   start_w2 = ~busy_o & ~hw_stby_s & ((tick & ~cfg_q[`CFG_STBY]) | oneshot);
  wire   conv_end = busy_o & (conv_cnt_q == '0);
  wire   clr_stat = ev_read & (ptr_q == `CMD_RD_STATUS);
  // signed compares on two's complement limits
  wire   [6:2] cond_w = {$signed(ltemp_q) >= $signed(lhl_q),
                         $signed(ltemp_q) <= $signed(lll_q),
                         ($signed(rtemp_q) >= $signed(rhl_q)) | fault_q,
                         $signed(rtemp_q) <= $signed(rll_q),
                         fault_open_q};
  wire   [6:2] set_w  = post_q ? cond_w : 5'h00;
  wire   [6:2] flag_d = (clr_stat ? cond_w : flags_q[6:2]) | set_w;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ev_seen_q    <= 1'b0;
      ptr_q        <= `PTR_RST;
      rate_q       <= `RATE_RST;
      cfg_q        <= `CFG_RST;
      lhl_q        <= `HI_LIM_RST;
      rhl_q        <= `HI_LIM_RST;
      lll_q        <= `LO_LIM_RST;
      rll_q        <= `LO_LIM_RST;
      ltemp_q      <= 8'h00;
      rtemp_q      <= 8'h00;
      flags_q      <= 8'h00;
      busy_o       <= 1'b0;
      conv_cnt_q   <= '0;
      fault_q      <= 1'b0;
      fault_open_q <= 1'b0;
      post_q       <= 1'b0;
      rd_byte_q    <= 8'h00;
      rd_tgl_q     <= 1'b0;
      alert_o      <= 1'b0;
      alert_oe_o   <= 1'b0;
    end else begin
      ev_seen_q <= ev_tgl_s;
      alert_o   <= 1'b0;
      post_q    <= conv_end;
      if (ev_cmd) begin
        ptr_q <= ev_byte_q;
      end
      if (ev_data) begin
        case (ptr_q)
          `CMD_WR_CFG:  cfg_q  <= ev_byte_q;
          `CMD_WR_RATE: rate_q <= ev_byte_q;
          `CMD_WR_LHL:  lhl_q  <= ev_byte_q;
          `CMD_WR_LLL:  lll_q  <= ev_byte_q;
          `CMD_WR_RHL:  rhl_q  <= ev_byte_q;
          `CMD_WR_RLL:  rll_q  <= ev_byte_q;
          default:      ;
        endcase
      end
      if (ev_read) begin
        rd_byte_q <= rd_mux(ptr_q);
        rd_tgl_q  <= ~rd_tgl_q;
      end
      flags_q[6:2] <= flag_d;
      if (post_q && |cond_w) begin
        alert_oe_o <= 1'b1;
      end
      if (start_w2) begin
        busy_o       <= 1'b1;
        conv_cnt_q   <= CW'(CONV_CYCLES - 1);
        fault_q      <= open_s | short_s;
        fault_open_q <= open_s;
      end else if (conv_end) begin
        busy_o  <= 1'b0;
        ltemp_q <= ltemp_s;
        rtemp_q <= fault_q ? `FAULT_TEMP : rtemp_s;
      end else if (busy_o) begin
        conv_cnt_q <= conv_cnt_q - 1'b1;
      end
    end
  end

  a_reset_defaults: assert property (@(posedge mclk_i) disable iff (rst_i)
    $past(rst_i) |-> !alert_oe_o && rate_q == `RATE_RST && ptr_q == `PTR_RST)
    else $error("wrong power-up defaults");
  a_reset_limits: assert property (@(posedge mclk_i) disable iff (rst_i)
    $past(rst_i) |-> lhl_q == 8'h7F && rll_q == 8'hC9 && rhl_q == lhl_q && lll_q == rll_q)
    else $error("wrong power-up limits");
  a_fault_capture: assert property (@(posedge mclk_i) disable iff (rst_i)
    start_w2 |=> fault_q == $past(open_s | short_s)) else $error("fault not sampled at start");
  a_fault_effects: assert property (@(posedge mclk_i) disable iff (rst_i)
    conv_end && fault_q |=> rtemp_q == 8'h7F ##1 flags_q[4] && alert_oe_o)
    else $error("diode fault not reported");
  a_open_flag: assert property (@(posedge mclk_i) disable iff (rst_i)
    conv_end && fault_open_q |=> ##1 flags_q[2]) else $error("open flag not set");
  a_oneshot_blocked: assert property (@(posedge mclk_i) disable iff (rst_i)
    oneshot && hw_stby_s && !busy_o |=> !busy_o) else $error("one-shot ran in hw standby");
  a_oneshot_runs: assert property (@(posedge mclk_i) disable iff (rst_i)
    oneshot && !hw_stby_s && !busy_o |=> busy_o && conv_cnt_q == CW'(CONV_CYCLES - 1))
    else $error("one-shot did not start");
  a_status_clear: assert property (@(posedge mclk_i) disable iff (rst_i)
    clr_stat && !post_q |=> flags_q[6:2] == $past(cond_w)) else $error("status not cleared");
  a_ptr_load: assert property (@(posedge mclk_i) disable iff (rst_i)
    ev_cmd |=> ptr_q == $past(ev_byte_q)) else $error("pointer not updated");
endmodule

// file: dv/smbus_host_model.sv
`timescale 1ns/100ps
module smbus_host_model #(
  parameter int Q = 20
) (
  input  wire logic clk_i,
  input  wire logic dut_oe_i,
  output logic      scl_o,
  output wire logic sda_o
);
  logic drv_low;

  // pull-up: line reads high unless a party pulls it low
  assign sda_o = ~(drv_low | dut_oe_i);

  initial begin
    scl_o = 1'b1;
    drv_low = 1'b0;
  end

  // quarter bit time, moves just after a clock edge
  task automatic q_wait(input int n);
    repeat (n * Q) @(posedge clk_i);
    #1;
  endtask

  // also serves as repeated start: data released before clock rises
  task automatic start_c;
    drv_low = 1'b0;
    q_wait(1);
    scl_o = 1'b1;
    q_wait(1);
    drv_low = 1'b1;
    q_wait(1);
    scl_o = 1'b0;
    q_wait(1);
  endtask

  task automatic stop_c;
    drv_low = 1'b1;
    q_wait(1);
    scl_o = 1'b1;
    q_wait(1);
    drv_low = 1'b0;
    q_wait(2);
  endtask

  task automatic put_bit(input logic b);
    drv_low = ~b;
    q_wait(1);
    scl_o = 1'b1;
    q_wait(2);
    scl_o = 1'b0;
    q_wait(1);
  endtask

  task automatic get_bit(output logic b);
    drv_low = 1'b0;
    q_wait(1);
    scl_o = 1'b1;
    q_wait(1);
    b = sda_o;
    q_wait(1);
    scl_o = 1'b0;
    q_wait(1);
  endtask

  // eight data bits then the acknowledge slot
  task automatic wr8(input logic [7:0] d, inout logic ok);
    logic a;
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(a);
    ok = ok & ~a;
  endtask

  task automatic rd8(output logic [7:0] d);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(1'b1);
  endtask

  // k: 0 write byte, 1 read byte, 2 send byte, 3 receive byte
  task automatic xfer(input int k, input logic [6:0] a, input logic [7:0] c,
                      input logic [7:0] d, output logic [7:0] r, output logic ok);
    ok = 1'b1;
    r = 8'h00;
    start_c();
    if (k < 3) begin
      wr8({a, 1'b0}, ok);
      wr8(c, ok);
    end
    if (k == 0) wr8(d, ok);
    if (k == 1) start_c();
    if (k == 1 || k == 3) begin
      wr8({a, 1'b1}, ok);
      rd8(r);
    end
    stop_c();
  endtask
endmodule

// file: dv/testbench.sv
`timescale 1ns/100ps
`include "temp_mon_map.svh"
module testbench;
  import temp_mon_pkg::*;
  localparam logic [6:0] ADDR = 7'h2A;
  logic  mclk, lclk, rst, scl, sda, alert_oe, busy, sda_oe;
  logic  dopen, dshort, stby, ok, sda_val, alert_val;
  byte_t ltemp, rtemp, rd;
  int    bad_count, cmp_count, convs, n, m;

  smbus_temp_monitor_slave_port #(.CONV_CYCLES(50), .RATE_CYCLES(2048)) i_dut (
    .mclk_i(mclk), .rst_i(rst), .link_clk_i(lclk), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_val), .sda_oe_o(sda_oe), .dev_addr_i(ADDR), .alert_o(alert_val),
    .alert_oe_o(alert_oe),
    .local_temp_i(ltemp), .remote_temp_i(rtemp), .diode_open_i(dopen),
    .diode_short_i(dshort), .hw_standby_i(stby), .busy_o(busy));

  smbus_host_model #(.Q(20)) i_host (
    .clk_i(mclk), .dut_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // link clock with its own phase
  initial begin
    lclk = 1'b0;
    #7;
    forever #32 lclk = ~lclk;
  end

  always @(posedge busy) convs++;

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input string s, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", s, exp, seen);
    end
  endtask

  task automatic wait_busy(input logic lvl, input int lim, output int cnt);
    cnt = 0;
    while (busy !== lvl) begin
      @(posedge mclk);
      #1;
      cnt++;
      if (cnt > lim) begin
        bad_count++;
        $display("BAD busy wait level %b", lvl);
        tally_and_finish();
      end
    end
  endtask

  task automatic tx(input int k, input byte_t c, input byte_t d = 8'h00);
    i_host.xfer(k, ADDR, c, d, rd, ok);
    check("acks", {15'h0000, ok}, 16'h0001);
  endtask

  task automatic rdx(input byte_t c, input byte_t e, input byte_t msk);
    tx(1, c);
    check($sformatf("reg %h", c), {8'h00, rd & msk}, {8'h00, e});
  endtask

  task automatic t_power_up;
    check("alert idle", {15'h0000, alert_oe}, 16'h0000);
    check("data idle", {15'h0000, sda_oe}, 16'h0000);
    check("pin values", {14'h0000, sda_val, alert_val}, 16'h0000);
    wait_busy(1'b1, 1100, n);
    wait_busy(1'b0, 60, n);
    wait_busy(1'b1, 600, m);
    check("auto interval", 16'(n + m), 16'h0200);
    wait_busy(1'b0, 60, n);
    tx(3, 8'h00);
    check("receive after reset", {8'h00, rd}, {8'h00, ltemp});
  endtask

  task automatic t_defaults;
    byte_t exp [5] = '{8'h02, 8'h7F, 8'hC9, 8'h7F, 8'hC9};
    for (int i = 0; i < 5; i++) begin
      rdx(8'(`CMD_RD_RATE + i), exp[i], 8'hFF);
    end
    rdx(`CMD_RD_STATUS, 8'h00, 8'h7F);
  endtask

  task automatic t_foreign;
    i_host.xfer(0, ADDR ^ 7'h01, `CMD_WR_RHL, 8'h05, rd, ok);
    check("foreign ack", {15'h0000, ok}, 16'h0000);
    rdx(`CMD_RD_RHL, 8'h7F, 8'hFF);
  endtask

  // a faster rate code must shorten the timer interval
  task automatic t_rate;
    tx(0, `CMD_WR_RATE, 8'h03);
    rdx(`CMD_RD_RATE, 8'h03, 8'hFF);
    wait_busy(1'b0, 60, n);
    wait_busy(1'b1, 300, n);
    wait_busy(1'b0, 60, n);
    wait_busy(1'b1, 300, m);
    check("rate 03 interval", 16'(n + m), 16'h0100);
  endtask

  // timer keeps running here, so several conversions see each fault
  task automatic t_diode;
    dshort = 1'b1;
    tx(2, `CMD_ONESHOT);
    rdx(`CMD_RD_RTEMP, 8'h7F, 8'hFF);
    rdx(`CMD_RD_STATUS, 8'h10, 8'h14);
    check("alert on fault", {14'h0000, alert_oe, alert_val}, 16'h0002);
    dshort = 1'b0;
    dopen = 1'b1;
    tx(2, `CMD_ONESHOT);
    rdx(`CMD_RD_STATUS, 8'h14, 8'h14);
    dopen = 1'b0;
    tx(2, `CMD_ONESHOT);
    rdx(`CMD_RD_STATUS, 8'h14, 8'h14);
    rdx(`CMD_RD_STATUS, 8'h00, 8'h14);
  endtask

  // software standby masks the timer ticks, so only one-shots convert
  task automatic t_oneshot;
    tx(0, `CMD_WR_CFG, 8'h40);
    repeat (600) @(posedge mclk);
    n = convs;
    repeat (1100) @(posedge mclk);
    check("standby idle", 16'(convs - n), 16'h0000);
    tx(0, `CMD_WR_RHL, 8'h1A);
    rdx(`CMD_RD_RHL, 8'h1A, 8'hFF);
    n = convs;
    tx(2, `CMD_ONESHOT);
    check("one-shot count", 16'(convs - n), 16'h0001);
    rdx(`CMD_RD_STATUS, 8'h10, 8'h7C);
    tx(3, 8'h00);
    check("receive status", {8'h00, rd & 8'h7C}, 16'h0010);
    tx(0, `CMD_WR_RHL, 8'h7F);
    rdx(`CMD_RD_STATUS, 8'h10, 8'h7C);
    rdx(`CMD_RD_STATUS, 8'h00, 8'h7C);
  endtask

  task automatic t_hw_standby;
    stby = 1'b1;
    n = convs;
    tx(2, `CMD_ONESHOT);
    check("hw standby inhibit", 16'(convs - n), 16'h0000);
    stby = 1'b0;
  endtask

  // latch set by earlier faults must clear on a reset in mid-run
  task automatic t_reset_again;
    check("alert before reset", {15'h0000, alert_oe}, 16'h0001);
    rst = 1'b1;
    repeat (8) @(posedge mclk);
    #1;
    rst = 1'b0;
    check("alert after reset", {14'h0000, alert_oe, alert_val}, 16'h0000);
    wait_busy(1'b1, 1100, n);
    wait_busy(1'b0, 60, n);
    tx(3, 8'h00);
    check("pointer after reset", {8'h00, rd}, {8'h00, ltemp});
    rdx(`CMD_RD_RATE, 8'h02, 8'hFF);
  endtask

  initial begin
    {rst, dopen, dshort, stby} = 4'h8;
    ltemp = 8'h19;
    rtemp = 8'h1E;
    bad_count = 0;
    cmp_count = 0;
    repeat (8) @(posedge mclk);
    #1;
    rst = 1'b0;
    t_power_up();
    t_defaults();
    t_foreign();
    t_rate();
    t_diode();
    t_oneshot();
    t_hw_standby();
    t_reset_again();
    tally_and_finish();
  end
endmodule
